/* File: bench/rag_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Program ROM with asynchronous read.
// The content is a fixed pattern of the address so that every word is known to the bench
// and both table flags take all four combinations as the low address bits change.
module rag_rom_model (
   // Address from the core
   input wire logic [13:0] addr_in,
   // Word back to the core
   output logic [9:0] data_out
);
   assign data_out = {addr_in[1:0], addr_in[9:2] ^ addr_in[13:6]};
endmodule
`default_nettype wire

/* File: bench/tb_rom_ram_address_generation.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rom_ram_address_generation;
   logic clk_in, rst_n_in, op_valid_in, ready_out;
   rag_pkg::rag_op_t op_kind_in;
   logic [13:0] imm_in, rom_addr_out, program_counter_out, pc_exp;
   logic [3:0] acc_in, breg_in, xptr_in, yptr_in;
   logic [1:0] wptr_in;
   logic [9:0] rom_data_in, ram_addr_out;
   logic ram_addr_valid_out, acc_wr_out, port_wr_out;
   logic [3:0] acc_data_out, breg_data_out, r1_data_out, r2_data_out;
   logic [31:0] seed, r;
   // Contents that the table reference registers must hold between loads.
   logic [7:0] ab_exp, pr_exp;
   int error_cnt, n_tests, cyc;
   rag_addr_gen rag_addr_gen_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .op_valid_in(op_valid_in), .op_kind_in(op_kind_in), .imm_in(imm_in),
      .ready_out(ready_out), .acc_in(acc_in), .breg_in(breg_in), .wptr_in(wptr_in),
      .xptr_in(xptr_in), .yptr_in(yptr_in), .rom_addr_out(rom_addr_out),
      .rom_data_in(rom_data_in), .program_counter_out(program_counter_out),
      .ram_addr_out(ram_addr_out), .ram_addr_valid_out(ram_addr_valid_out),
      .acc_wr_out(acc_wr_out), .acc_data_out(acc_data_out), .breg_data_out(breg_data_out),
      .port_wr_out(port_wr_out), .r1_data_out(r1_data_out), .r2_data_out(r2_data_out));
   rag_rom_model rag_rom_model_i (.addr_in(rom_addr_out), .data_out(rom_data_in));
   // ==========================================================
   // Clock, watchdog and helpers
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // The run needs well under a thousand cycles; the ceiling leaves ample margin.
   always @(posedge clk_in) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         conclude();
      end
   end
   function automatic logic [31:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [9:0] rom_word(input logic [13:0] a);
      return {a[1:0], a[9:2] ^ a[13:6]};
   endfunction
   task automatic report(input logic [13:0] got, input logic [13:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pc(input logic [13:0] got, input logic [13:0] exp);
      report(got, exp);
   endtask
   task automatic chk_ram(input logic [9:0] got, input logic [9:0] exp);
      report({4'h0, got}, {4'h0, exp});
   endtask
   task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
      report({10'h000, got}, {10'h000, exp});
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      report({13'h0000, got}, {13'h0000, exp});
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Stimulus tasks, entered and left at a falling edge
   task automatic reset_dut();
      rst_n_in = 1'b0;
      op_valid_in = 1'b0;
      repeat (5) @(negedge clk_in);
      chk_pc(program_counter_out, 14'h0000);
      chk_pc(rom_addr_out, 14'h0000);
      chk_ram(ram_addr_out, 10'h000);
      chk_bit(ready_out, 1'b1);
      chk_bit(acc_wr_out | port_wr_out | ram_addr_valid_out, 1'b0);
      chk_nib(acc_data_out | breg_data_out, 4'h0);
      chk_nib(r1_data_out | r2_data_out, 4'h0);
      ab_exp = 8'h00;
      pr_exp = 8'h00;
      rst_n_in = 1'b1;
      pc_exp = 14'h0000;
   endtask
   task automatic idle();
      op_valid_in = 1'b0;
      @(negedge clk_in);
      chk_pc(program_counter_out, pc_exp);
      chk_bit(ram_addr_valid_out, 1'b0);
   endtask
   task automatic do_op(input rag_pkg::rag_op_t k, input logic [13:0] imm,
                        input logic [3:0] a, input logic [3:0] b);
      logic [13:0] tadr;
      logic [9:0] w;
      chk_bit(ready_out, 1'b1);
      r = nxt();
      {wptr_in, xptr_in, yptr_in} = r[9:0];
      op_kind_in = k;
      imm_in = imm;
      acc_in = a;
      breg_in = b;
      op_valid_in = 1'b1;
      tadr = {2'b00, imm[3:0], a, b};
      @(negedge clk_in);
      case (k)
         rag_pkg::OP_LONG: pc_exp = imm;
         rag_pkg::OP_PAGE: pc_exp = {pc_exp[13:8] + {5'h00, &pc_exp[7:0]}, imm[7:0]};
         rag_pkg::OP_ZCALL: pc_exp = {8'h00, imm[5:0]};
         rag_pkg::OP_TBR: pc_exp = tadr;
         default: pc_exp = pc_exp + 14'h0001;
      endcase
      chk_pc(program_counter_out, pc_exp);
      chk_bit(ram_addr_valid_out, k == rag_pkg::OP_RAM_IND || k == rag_pkg::OP_MEMREG);
      chk_bit(acc_wr_out | port_wr_out, 1'b0);
      if (k == rag_pkg::OP_RAM_IND) chk_ram(ram_addr_out, {wptr_in, xptr_in, yptr_in});
      if (k == rag_pkg::OP_MEMREG) chk_ram(ram_addr_out, 10'h040 + {6'h00, imm[3:0]});
      if (k == rag_pkg::OP_TREF) begin
         chk_bit(ready_out, 1'b0);
         chk_pc(rom_addr_out, tadr);
         w = rom_word(tadr);
         @(negedge clk_in);
         chk_bit(acc_wr_out, w[8]);
         chk_bit(port_wr_out, w[9]);
         if (w[8]) ab_exp = w[7:0];
         if (w[9]) pr_exp = w[7:0];
         chk_nib(acc_data_out, ab_exp[7:4]);
         chk_nib(breg_data_out, ab_exp[3:0]);
         chk_nib(r1_data_out, pr_exp[7:4]);
         chk_nib(r2_data_out, pr_exp[3:0]);
         chk_pc(program_counter_out, pc_exp);
      end else if (k == rag_pkg::OP_RAM_DIR) begin
         chk_bit(ready_out, 1'b0);
         chk_pc(rom_addr_out, pc_exp);
         w = rom_word(pc_exp);
         @(negedge clk_in);
         pc_exp = pc_exp + 14'h0001;
         chk_bit(ram_addr_valid_out, 1'b1);
         chk_ram(ram_addr_out, w);
         chk_pc(program_counter_out, pc_exp);
      end
      chk_pc(rom_addr_out, pc_exp);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {op_valid_in, imm_in, acc_in, breg_in, wptr_in, xptr_in, yptr_in} = '0;
      op_kind_in = rag_pkg::OP_SEQ;
      rst_n_in = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      cyc = 0;
      seed = 32'h5d56;
      reset_dut();
      do_op(rag_pkg::OP_LONG, 14'h12ff, 4'h0, 4'h0);
      do_op(rag_pkg::OP_PAGE, 14'h0034, 4'h0, 4'h0);
      do_op(rag_pkg::OP_LONG, 14'h3fff, 4'h0, 4'h0);
      do_op(rag_pkg::OP_PAGE, 14'h3f77, 4'h0, 4'h0);
      do_op(rag_pkg::OP_ZCALL, 14'h3fff, 4'h0, 4'h0);
      do_op(rag_pkg::OP_LONG, 14'h0100, 4'h0, 4'h0);
      do_op(rag_pkg::OP_PAGE, 14'h00fe, 4'h0, 4'h0);
      do_op(rag_pkg::OP_TBR, 14'h3fff, 4'hf, 4'hf);
      $display("test branch corners done");
      for (int i = 0; i < 4; i++) do_op(rag_pkg::OP_TREF, 14'h0005, 4'ha, i[3:0]);
      do_op(rag_pkg::OP_RAM_DIR, 14'h0000, 4'h0, 4'h0);
      do_op(rag_pkg::OP_RAM_DIR, 14'h0000, 4'h0, 4'h0);
      do_op(rag_pkg::OP_MEMREG, 14'h0000, 4'h0, 4'h0);
      do_op(rag_pkg::OP_MEMREG, 14'h3fff, 4'h0, 4'h0);
      do_op(rag_pkg::OP_RAM_IND, 14'h0000, 4'h0, 4'h0);
      idle();
      $display("test table and data access done");
      for (int i = 0; i < 300; i++) begin
         r = nxt();
         if (r[31:29] == 3'h0) idle();
         else do_op(rag_pkg::rag_op_t'(r[27:24] % 4'h9), r[13:0], r[19:16], r[23:20]);
      end
      $display("test random mix done");
      do_op(rag_pkg::OP_LONG, 14'h2a5c, 4'h0, 4'h0);
      reset_dut();
      do_op(rag_pkg::OP_SEQ, 14'h0000, 4'h0, 4'h0);
      idle();
      $display("test reset in mid-run done");
      conclude();
   end
endmodule
`default_nettype wire

/* File: common/rag_pkg.sv */
`default_nettype none
package rag_pkg;
   // ==========================================================
   // Widths
   localparam int PC_W = 14;
   localparam int ROM_W = 10;
   localparam int RAM_AW = 10;
   localparam int NIB_W = 4;
   localparam int WPTR_W = 2;
   localparam int PAGE_LSB = 8;
   localparam int ZP_W = 6;
   // ==========================================================
   // Field positions in a referenced ROM word
   localparam int FLAG_ACC_BIT = 8;
   localparam int FLAG_PORT_BIT = 9;
   // ==========================================================
   // Fixed addresses and reset values
   localparam logic [9:0] MEMREG_BASE = 10'h040;
   localparam logic [13:0] PC_RST = 14'h0000;
   localparam logic [13:0] PC_STEP = 14'h0001;
   localparam logic [9:0] RAM_ADDR_RST = 10'h000;
   localparam logic [3:0] NIB_RST = 4'h0;
   // ==========================================================
   // RAM addressing modes
   localparam logic [1:0] RAM_MODE_IND = 2'h0;
   localparam logic [1:0] RAM_MODE_DIR = 2'h1;
   localparam logic [1:0] RAM_MODE_MREG = 2'h2;
   // ==========================================================
   // Instruction classes handed over by the decoder
   typedef enum logic [3:0] {
      OP_SEQ,
      OP_LONG,
      OP_PAGE,
      OP_ZCALL,
      OP_TBR,
      OP_TREF,
      OP_RAM_IND,
      OP_RAM_DIR,
      OP_MEMREG
   } rag_op_t;
endpackage
`default_nettype wire

/* File: common/rag_ram_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rag_ram_if;
   logic req;
   logic [1:0] mode;
   logic [1:0] wptr;
   logic [3:0] xptr;
   logic [3:0] yptr;
   logic [9:0] dir_word;
   logic [3:0] mreg_idx;
   logic [9:0] addr;
   logic valid;
   modport core (
      output req, mode, wptr, xptr, yptr, dir_word, mreg_idx,
      input addr, valid
   );
   modport gen (
      input req, mode, wptr, xptr, yptr, dir_word, mreg_idx,
      output addr, valid
   );
endinterface
`default_nettype wire

/* File: design/rag_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module rag_addr_gen (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Decoded instruction
   input wire logic op_valid_in,
   input wire rag_pkg::rag_op_t op_kind_in,
   input wire logic [13:0] imm_in,
   output logic ready_out,
   // Core register contents
   input wire logic [3:0] acc_in,
   input wire logic [3:0] breg_in,
   input wire logic [1:0] wptr_in,
   input wire logic [3:0] xptr_in,
   input wire logic [3:0] yptr_in,
   // Program ROM
   output logic [13:0] rom_addr_out,
   input wire logic [9:0] rom_data_in,
   // Program counter
   output logic [13:0] program_counter_out,
   // Data RAM
   output logic [9:0] ram_addr_out,
   output logic ram_addr_valid_out,
   // Table reference results
   output logic acc_wr_out,
   output logic [3:0] acc_data_out,
   output logic [3:0] breg_data_out,
   output logic port_wr_out,
   output logic [3:0] r1_data_out,
   output logic [3:0] r2_data_out
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DIR,
      ST_TREF
   } rag_state_t;

   rag_state_t state_r;
   rag_state_t state_nxt;
   logic [13:0] pc_r;
   logic [13:0] pc_nxt;
   logic [13:0] pc_inc;
   logic [13:0] tbl_addr;
   logic [13:0] rom_addr_r;
   logic [13:0] rom_addr_nxt;
   logic take;
   logic acc_wr_r;
   logic port_wr_r;
   logic [3:0] acc_r;
   logic [3:0] breg_r;
   logic [3:0] r1_r;
   logic [3:0] r2_r;

   rag_ram_if ram ();

   rag_ram_addr u_ram_addr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .bus(ram)
   );

   // ==========================================================
   // Request acceptance
   // A two-word or table access holds the decoder off for one cycle, so the
   // ROM port is never wanted by two things at once.
   assign ready_out = state_r == ST_IDLE;
   assign take = op_valid_in && ready_out;
   assign pc_inc = pc_r + rag_pkg::PC_STEP;
   assign tbl_addr = {2'b00, imm_in[3:0], acc_in, breg_in};

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (take && op_kind_in == rag_pkg::OP_RAM_DIR) begin
               state_nxt = ST_DIR;
            end else if (take && op_kind_in == rag_pkg::OP_TREF) begin
               state_nxt = ST_TREF;
            end
         end
         ST_DIR: state_nxt = ST_IDLE;
         ST_TREF: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Program counter
   // The page branch takes its page from the stepped counter, so a branch in
   // the last word of a page lands in the next page.
   always_comb begin
      pc_nxt = pc_r;
      if (state_r == ST_DIR) begin
         pc_nxt = pc_inc;
      end else if (take) begin
         case (op_kind_in)
            rag_pkg::OP_LONG: pc_nxt = imm_in;
            rag_pkg::OP_PAGE: pc_nxt = {pc_inc[13:8], imm_in[7:0]};
            rag_pkg::OP_ZCALL: pc_nxt = {8'h00, imm_in[5:0]};
            rag_pkg::OP_TBR: pc_nxt = tbl_addr;
            rag_pkg::OP_TREF: pc_nxt = pc_inc;
            default: pc_nxt = pc_inc;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_r <= rag_pkg::PC_RST;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   // ==========================================================
   // ROM address
   // The ROM is read asynchronously: its word belongs to the address shown
   // in the same cycle. A table reference borrows the port for one cycle.
   always_comb begin
      if (take && op_kind_in == rag_pkg::OP_TREF) begin
         rom_addr_nxt = tbl_addr;
      end else begin
         rom_addr_nxt = pc_nxt;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rom_addr_r <= rag_pkg::PC_RST;
      end else begin
         rom_addr_r <= rom_addr_nxt;
      end
   end

   // ==========================================================
   // RAM address requests
   always_comb begin
      ram.req = 1'b0;
      ram.mode = rag_pkg::RAM_MODE_IND;
      if (state_r == ST_DIR) begin
         ram.req = 1'b1;
         ram.mode = rag_pkg::RAM_MODE_DIR;
      end else if (take && op_kind_in == rag_pkg::OP_RAM_IND) begin
         ram.req = 1'b1;
         ram.mode = rag_pkg::RAM_MODE_IND;
      end else if (take && op_kind_in == rag_pkg::OP_MEMREG) begin
         ram.req = 1'b1;
         ram.mode = rag_pkg::RAM_MODE_MREG;
      end
   end

   assign ram.wptr = wptr_in;
   assign ram.xptr = xptr_in;
   assign ram.yptr = yptr_in;
   assign ram.dir_word = rom_data_in;
   assign ram.mreg_idx = imm_in[3:0];

   // ==========================================================
   // Table reference write-back
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_wr_r <= 1'b0;
         port_wr_r <= 1'b0;
      end else begin
         acc_wr_r <= state_r == ST_TREF && rom_data_in[rag_pkg::FLAG_ACC_BIT];
         port_wr_r <= state_r == ST_TREF && rom_data_in[rag_pkg::FLAG_PORT_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_r <= rag_pkg::NIB_RST;
         breg_r <= rag_pkg::NIB_RST;
      end else if (state_r == ST_TREF && rom_data_in[rag_pkg::FLAG_ACC_BIT]) begin
         acc_r <= rom_data_in[7:4];
         breg_r <= rom_data_in[3:0];
      end
   end

   // The port output registers live here, so they keep their value between
   // table references.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r1_r <= rag_pkg::NIB_RST;
         r2_r <= rag_pkg::NIB_RST;
      end else if (state_r == ST_TREF && rom_data_in[rag_pkg::FLAG_PORT_BIT]) begin
         r1_r <= rom_data_in[7:4];
         r2_r <= rom_data_in[3:0];
      end
   end

   // ==========================================================
   // Outputs
   assign program_counter_out = pc_r;
   assign rom_addr_out = rom_addr_r;
   assign ram_addr_out = ram.addr;
   assign ram_addr_valid_out = ram.valid;
   assign acc_wr_out = acc_wr_r;
   assign acc_data_out = acc_r;
   assign breg_data_out = breg_r;
   assign port_wr_out = port_wr_r;
   assign r1_data_out = r1_r;
   assign r2_data_out = r2_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence dir_go;
      take && op_kind_in == rag_pkg::OP_RAM_DIR;
   endsequence

   sequence tref_go;
      take && op_kind_in == rag_pkg::OP_TREF;
   endsequence

   sequence tref_acc_hit;
      tref_go ##1 rom_data_in[rag_pkg::FLAG_ACC_BIT];
   endsequence

   sequence tref_port_hit;
      tref_go ##1 rom_data_in[rag_pkg::FLAG_PORT_BIT];
   endsequence

   ram_indirect_a: assert property (
      take && op_kind_in == rag_pkg::OP_RAM_IND |=> ram_addr_valid_out
      && ram_addr_out == {$past(wptr_in), $past(xptr_in), $past(yptr_in)})
      else $error("indirect RAM address does not match the pointers");

   ram_direct_a: assert property (
      dir_go |=> !ready_out ##1 ram_addr_valid_out && ram_addr_out == $past(rom_data_in))
      else $error("direct RAM address is not the second word");

   memreg_addr_a: assert property (
      take && op_kind_in == rag_pkg::OP_MEMREG |=> ram_addr_valid_out
      && ram_addr_out == {6'h04, $past(imm_in[3:0])})
      else $error("memory register address is wrong");

   pc_long_a: assert property (
      take && op_kind_in == rag_pkg::OP_LONG |=> program_counter_out == $past(imm_in))
      else $error("long transfer did not load the full counter");

   pc_page_a: assert property (
      take && op_kind_in == rag_pkg::OP_PAGE && program_counter_out[7:0] != 8'hff
      |=> program_counter_out == {$past(program_counter_out[13:8]), $past(imm_in[7:0])})
      else $error("page branch left its page or missed its target");

   page_wrap_a: assert property (
      take && op_kind_in == rag_pkg::OP_PAGE && program_counter_out[7:0] == 8'hff
      |=> program_counter_out[13:8] == $past(program_counter_out[13:8]) + 6'h01)
      else $error("page branch at page end did not move to the next page");

   pc_zcall_a: assert property (
      take && op_kind_in == rag_pkg::OP_ZCALL
      |=> program_counter_out == {8'h00, $past(imm_in[5:0])})
      else $error("zero-page call target is wrong");

   pc_table_a: assert property (
      take && op_kind_in == rag_pkg::OP_TBR
      |=> program_counter_out == {2'b00, $past(imm_in[3:0]), $past(acc_in), $past(breg_in)})
      else $error("table branch target is wrong");

   tref_acc_a: assert property (
      tref_acc_hit |=> acc_wr_out && {acc_data_out, breg_data_out} == $past(rom_data_in[7:0]))
      else $error("table reference did not load accumulator and B");

   tref_port_a: assert property (
      tref_port_hit |=> port_wr_out && {r1_data_out, r2_data_out} == $past(rom_data_in[7:0]))
      else $error("table reference did not load the port registers");

   tref_pc_a: assert property (
      tref_go |=> rom_addr_out == $past(tbl_addr) ##1
      program_counter_out == $past(program_counter_out, 2) + rag_pkg::PC_STEP
      && rom_addr_out == program_counter_out)
      else $error("table reference disturbed the counter");
endmodule
`default_nettype wire

/* File: design/rag_ram_addr.sv */
`timescale 1ns/1ps
`default_nettype none
module rag_ram_addr (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Request from the sequencer
   rag_ram_if.gen bus
);
   logic [9:0] addr_r;
   logic valid_r;
   logic mreg_r;

   // ==========================================================
   // Address former
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         addr_r <= rag_pkg::RAM_ADDR_RST;
      end else if (bus.req) begin
         case (bus.mode)
            rag_pkg::RAM_MODE_IND: addr_r <= {bus.wptr, bus.xptr, bus.yptr};
            rag_pkg::RAM_MODE_DIR: addr_r <= bus.dir_word;
            rag_pkg::RAM_MODE_MREG: addr_r <= rag_pkg::MEMREG_BASE | {6'h00, bus.mreg_idx};
            default: addr_r <= addr_r;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         valid_r <= 1'b0;
         mreg_r <= 1'b0;
      end else begin
         valid_r <= bus.req;
         mreg_r <= bus.req && bus.mode == rag_pkg::RAM_MODE_MREG;
      end
   end

   assign bus.addr = addr_r;
   assign bus.valid = valid_r;

   // ==========================================================
   // Checks
   mreg_window_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mreg_r |-> valid_r && addr_r[9:4] == 6'h04)
      else $error("memory register address outside its window");
endmodule
`default_nettype wire
